// ==== rtl/per_sensor_exposure_regs.sv ====
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
// Operation
// R1 - Read-only pointer gives bank base offset
// R2 - Bit 0 reads feature present flag
// R3 - Gain enable bit shared by all sensors
// R4 - Gain enable is inverse of global gain
// R5 - Gain enable write sets autoexp inverse
// R6 - Disabled register ignores mode, value writes
// R7 - Bit 7 selects manual or automatic
// R8 - Gain value field, ignored in auto
// R9 - Shutter enable bit shared by all sensors
// R10 - Shutter enable is inverse of global shutter
// R11 - Shutter enable write sets autoexp inverse
// R12 - Autoexp enable bit shared by all sensors
// R13 - Autoexp write sets gain, shutter inverse
// R14 - Shutter value field, ignored in auto
// R15 - Autoexp value field, ignored in auto
// R16 - Six groups 20h apart, three registers
// R17 - Global register off freezes other fields
// R18 - Reserved bits read zero, ignore writes
// R19 - Empty bank offsets read zero, harmless
module per_sensor_exposure_regs #(
  parameter int unsigned ADDR_W    = 16,                          // Byte address width
  parameter logic [31:0] BANK_BASE = exposure_pkg::DEF_BANK_BASE, // Where the sensor bank sits
  parameter logic        PRESENT   = 1'b1                         // Feature present flag value
) (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  // Wishbone classic slave
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  input  wire logic                              we_i,
  input  wire logic [ADDR_W-1:0]                 adr_i,
  input  wire logic [exposure_pkg::DATA_W-1:0]   dat_i,
  input  wire logic [exposure_pkg::SEL_W-1:0]    sel_i,
  output      logic [exposure_pkg::DATA_W-1:0]   dat_o,
  output      logic                              ack_o,
  // Shared enables toward the exposure logic
  output      logic                              gainEnable,
  output      logic                              shutterEnable,
  output      logic                              autoExpEnable
);
  import exposure_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_state_t          busQ;          // Bus handshake state
  bus_state_t          busD;
  logic [DATA_W-1:0]   datQ;          // Registered read data
  logic [DATA_W-1:0]   datD;
  logic                gainEnQ;       // Shared per-sensor gain enable
  logic                gainEnD;
  logic                shutEnQ;       // Shared per-sensor shutter enable
  logic                shutEnD;
  logic                aeEnQ;         // Shared per-sensor autoexp enable
  logic                aeEnD;

  logic                request;       // Live request on the bus
  logic                wrFire;        // Write commits at this edge
  logic [31:0]         adrWide;       // Address widened to pointer width
  logic [31:0]         bankOfs;       // Offset within the bank
  logic                inBank;        // Address falls in the bank span
  logic [SENSOR_W-1:0] sensorIdx;     // Group number
  logic [KIND_W-1:0]   kindIdx;       // Register within group
  logic                hit;           // Address maps to a control register
  logic [REG_IDX_W-1:0] regIdx;       // Which control register
  logic                isPointer;     // Address is the bank pointer
  logic                ctlWrite;      // Committed write touching the enable lane
  logic                newBit;        // Written enable value

  logic [NUM_REGS-1:0] regEnable;     // Enable seen by each register
  logic [NUM_REGS-1:0] regMode;       // Mode bits gathered
  logic [VALUE_W-1:0]  regValue [NUM_REGS];  // Value fields gathered

  sensor_reg_if regIf [NUM_REGS] ();  // One link per store

  // ----------------------------------------------------------------
  // Read word layout
  // ----------------------------------------------------------------
  // Reserved ranges are built as zeros here, never stored
  function automatic logic [DATA_W-1:0] packWord(input logic en, input logic md,
                                                 input logic [VALUE_W-1:0] val);
    logic [DATA_W-1:0] w;
    w                        = READ_ZERO;  // R18
    w[PRESENT_BIT]           = PRESENT;    // R2
    w[ENABLE_BIT]            = en;
    w[MODE_BIT]              = md;
    w[VALUE_LSB +: VALUE_W]  = val;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Pure decode of the held request; the master keeps it stable
  always_comb begin
    adrWide   = {{(32-ADDR_W){1'b0}}, adr_i};
    bankOfs   = adrWide - BANK_BASE;
    inBank    = (adrWide >= BANK_BASE) && (bankOfs < BANK_SPAN);
    sensorIdx = bankOfs[SENSOR_LSB +: SENSOR_W];
    kindIdx   = bankOfs[KIND_LSB +: KIND_W];
    isPointer = (adrWide[31:KIND_LSB] == OFS_BASE_POINTER[31:KIND_LSB]);
    hit       = 1'b0;
    regIdx    = '0;
    if (inBank && (kindIdx < KIND_W'(NUM_KINDS))) begin  // R16
      hit    = 1'b1;
      regIdx = REG_IDX_W'({sensorIdx, 1'b0}) + REG_IDX_W'(sensorIdx) + REG_IDX_W'(kindIdx);
    end else if (adrWide[31:KIND_LSB] == OFS_GLOBAL_SHUTTER[31:KIND_LSB]) begin
      hit    = 1'b1;
      regIdx = IDX_GLOBAL_SHUTTER;
    end else if (adrWide[31:KIND_LSB] == OFS_GLOBAL_GAIN[31:KIND_LSB]) begin
      hit    = 1'b1;
      regIdx = IDX_GLOBAL_GAIN;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake, next state
  // ----------------------------------------------------------------
  // One wait state: data is sampled into datQ while ack rises, and
  // the write lands at the edge where the master sees ack
  always_comb begin
    request = cyc_i && stb_i;
    wrFire  = (busQ == BUS_ACK) && request && we_i;
    busD    = busQ;
    datD    = datQ;
    case (busQ)
      BUS_IDLE: begin
        if (request) begin
          busD = BUS_ACK;
          if (we_i) begin
            datD = READ_ZERO;
          end else if (isPointer) begin
            datD = BANK_BASE;  // R1
          end else if (hit) begin
            datD = packWord(regEnable[regIdx], regMode[regIdx], regValue[regIdx]);
          end else begin
            datD = READ_ZERO;  // R19
          end
        end
      end
      BUS_ACK: begin
        busD = BUS_IDLE;  // Ack lasts one cycle
      end
      default: begin
        busD = BUS_IDLE;
        datD = READ_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus handshake, registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busQ <= BUS_IDLE;
      datQ <= READ_ZERO;
    end else begin
      busQ <= busD;
      datQ <= datD;
    end
  end

  assign ack_o = (busQ == BUS_ACK);
  assign dat_o = datQ;

  // ----------------------------------------------------------------
  // Shared enable flags, next state
  // ----------------------------------------------------------------
  // Only three bits exist; the global on/off bits are their inverses,
  // so the coupling can never drift out of step
  always_comb begin
    ctlWrite = wrFire && hit && sel_i[LANE_CTL];
    newBit   = dat_i[ENABLE_BIT];
    gainEnD  = gainEnQ;
    shutEnD  = shutEnQ;
    aeEnD    = aeEnQ;
    if (ctlWrite) begin
      if (regIdx == IDX_GLOBAL_GAIN) begin
        gainEnD = !newBit;  // R4
      end else if (regIdx == IDX_GLOBAL_SHUTTER) begin
        shutEnD = !newBit;  // R10
      end else begin
        case (kindIdx)
          KIND_GAIN: begin
            gainEnD = newBit;   // R3
            aeEnD   = !newBit;  // R5
          end
          KIND_SHUTTER: begin
            shutEnD = newBit;   // R9
            aeEnD   = !newBit;  // R11
          end
          KIND_AUTOEXP: begin
            aeEnD   = newBit;   // R12
            gainEnD = !newBit;  // R13
            shutEnD = !newBit;  // R13
          end
          default: begin
            aeEnD = aeEnQ;  // Not reachable while hit is set
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared enable flags, registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gainEnQ <= RST_GAIN_EN;
      shutEnQ <= RST_SHUTTER_EN;
      aeEnQ   <= RST_AUTOEXP_EN;
    end else begin
      gainEnQ <= gainEnD;
      shutEnQ <= shutEnD;
      aeEnQ   <= aeEnD;
    end
  end

  assign gainEnable    = gainEnQ;
  assign shutterEnable = shutEnQ;
  assign autoExpEnable = aeEnQ;

  // ----------------------------------------------------------------
  // Mode and value stores
  // ----------------------------------------------------------------
  // Sensor registers take slots 0..17, globals the last two
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_store
    if (i == IDX_GLOBAL_GAIN) begin : g_gg
      assign regEnable[i] = !gainEnQ;  // R4 R17
    end else if (i == IDX_GLOBAL_SHUTTER) begin : g_gs
      assign regEnable[i] = !shutEnQ;  // R10 R17
    end else if ((i % NUM_KINDS) == KIND_GAIN) begin : g_sg
      assign regEnable[i] = gainEnQ;  // R3
    end else if ((i % NUM_KINDS) == KIND_SHUTTER) begin : g_ss
      assign regEnable[i] = shutEnQ;  // R9
    end else begin : g_sa
      assign regEnable[i] = aeEnQ;  // R12
    end

    assign regIf[i].wrEn   = wrFire && hit && (regIdx == REG_IDX_W'(i));
    assign regIf[i].wrData = dat_i;
    assign regIf[i].wrSel  = sel_i;
    assign regIf[i].enable = regEnable[i];
    assign regMode[i]      = regIf[i].mode;
    assign regValue[i]     = regIf[i].value;

    sensor_field_reg u_store (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .port    (regIf[i])
    );
  end

endmodule // per_sensor_exposure_regs

// ==== rtl/exposure_pkg.sv ====
package exposure_pkg;

  // ----------------------------------------------------------------
  // Bus and bank geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W       = 32;               // Wishbone data width
  localparam int unsigned SEL_W        = DATA_W / 8;       // Byte lanes
  localparam int unsigned NUM_SENSORS  = 6;                // Sensor groups in the bank
  localparam int unsigned NUM_KINDS    = 3;                // Gain, shutter, auto exposure
  localparam int unsigned NUM_REGS     = NUM_SENSORS * NUM_KINDS + 2;  // Plus two global registers
  localparam int unsigned REG_IDX_W    = 5;                // Wide enough for NUM_REGS
  localparam int unsigned KIND_LSB     = 2;                // Register within group, offset bits
  localparam int unsigned KIND_W       = 3;
  localparam int unsigned SENSOR_LSB   = 5;                // Group stride of 20h
  localparam int unsigned SENSOR_W     = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_BASE_POINTER   = 32'h0000_1E94;  // Read-only bank pointer
  localparam logic [31:0] OFS_GLOBAL_SHUTTER = 32'h0000_081C;  // Global shutter control
  localparam logic [31:0] OFS_GLOBAL_GAIN    = 32'h0000_0820;  // Global gain control
  localparam logic [31:0] DEF_BANK_BASE      = 32'h0000_2000;  // Default base of the sensor bank
  localparam logic [31:0] BANK_SPAN          = 32'h0000_00C0;  // Six groups of 20h
  localparam logic [KIND_W-1:0] KIND_GAIN    = 3'h0;           // Offset 00h in group
  localparam logic [KIND_W-1:0] KIND_SHUTTER = 3'h1;           // Offset 04h in group
  localparam logic [KIND_W-1:0] KIND_AUTOEXP = 3'h2;           // Offset 08h in group
  localparam logic [REG_IDX_W-1:0] IDX_GLOBAL_SHUTTER = 5'h12; // Slots after the sensor registers
  localparam logic [REG_IDX_W-1:0] IDX_GLOBAL_GAIN    = 5'h13;

  // ----------------------------------------------------------------
  // Field layout of every control register
  // ----------------------------------------------------------------
  localparam int unsigned PRESENT_BIT = 0;   // Feature present flag
  localparam int unsigned ENABLE_BIT  = 6;   // On/off
  localparam int unsigned MODE_BIT    = 7;   // 0 manual, 1 automatic
  localparam int unsigned VALUE_LSB   = 20;  // Value field 20..31
  localparam int unsigned VALUE_W     = 12;
  localparam int unsigned LOW_NIB_W   = 4;   // Value bits in byte lane 2
  localparam int unsigned HIGH_BYTE_W = 8;   // Value bits in byte lane 3
  localparam int unsigned LANE_CTL    = 0;   // Lane holding present, enable and mode
  localparam int unsigned LANE_VLO    = 2;
  localparam int unsigned LANE_VHI    = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic                RST_GAIN_EN    = 1'b0;
  localparam logic                RST_SHUTTER_EN = 1'b0;
  localparam logic                RST_AUTOEXP_EN = 1'b1;  // Inverse of the two above
  localparam logic                RST_MODE       = 1'b0;
  localparam logic [VALUE_W-1:0]  RST_VALUE      = 12'h000;
  localparam logic [DATA_W-1:0]   READ_ZERO      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,  // Waiting for a request
    BUS_ACK  = 2'b10   // Answer on the bus this cycle
  } bus_state_t;

endpackage

// ==== rtl/sensor_reg_if.sv ====
`timescale 1ns/1ps
// Link between the bank decoder and one mode/value store
interface sensor_reg_if;
  import exposure_pkg::*;
  logic                 wrEn;    // One-cycle committed write to this register
  logic [DATA_W-1:0]    wrData;  // Write data of the bus
  logic [SEL_W-1:0]     wrSel;   // Byte enables of the bus
  logic                 enable;  // Current on/off state seen by this register
  logic                 mode;    // Stored mode bit
  logic [VALUE_W-1:0]   value;   // Stored value field

  modport ctl   (output wrEn, output wrData, output wrSel, output enable, input mode, input value);
  modport store (input wrEn, input wrData, input wrSel, input enable, output mode, output value);
endinterface

// ==== rtl/sensor_field_reg.sv ====
`timescale 1ns/1ps
// Mode and value store of one control register
module sensor_field_reg (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Decoder side
  sensor_reg_if.store port
);
  import exposure_pkg::*;

  logic               modeQ;   // Manual/automatic
  logic               modeD;
  logic [VALUE_W-1:0] valueQ;  // Parameter value
  logic [VALUE_W-1:0] valueD;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Decisions use the state before the write, so one write that
  // turns auto off cannot also load a value
  always_comb begin
    modeD  = modeQ;
    valueD = valueQ;
    if (port.wrEn && port.enable) begin  // R6
      if (port.wrSel[LANE_CTL]) begin
        modeD = port.wrData[MODE_BIT];  // R7
      end
      if (!modeQ) begin  // R8 R14 R15
        if (port.wrSel[LANE_VLO]) begin
          valueD[LOW_NIB_W-1:0] = port.wrData[VALUE_LSB +: LOW_NIB_W];
        end
        if (port.wrSel[LANE_VHI]) begin
          valueD[VALUE_W-1:LOW_NIB_W] = port.wrData[VALUE_LSB+LOW_NIB_W +: HIGH_BYTE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeQ  <= RST_MODE;
      valueQ <= RST_VALUE;
    end else begin
      modeQ  <= modeD;
      valueQ <= valueD;
    end
  end

  assign port.mode  = modeQ;
  assign port.value = valueQ;

endmodule // sensor_field_reg

// ==== bench/per_sensor_exposure_regs_chk.sv ====
`timescale 1ns/1ps
module per_sensor_exposure_regs_chk
  import exposure_pkg::*;
#(
  parameter int unsigned ADDR_W    = 16,
  parameter logic [31:0] BANK_BASE = DEF_BANK_BASE,
  parameter logic        PRESENT   = 1'b1
) (
  // Clock and reset
  input logic                sys_clk,
  input logic                rst_n,
  // Bus
  input logic                cyc_i,
  input logic                stb_i,
  input logic                we_i,
  input logic [ADDR_W-1:0]   adr_i,
  input logic [DATA_W-1:0]   dat_i,
  input logic [SEL_W-1:0]    sel_i,
  input logic [DATA_W-1:0]   dat_o,
  input logic                ack_o,
  // Shared enables
  input logic                gainEnable,
  input logic                shutterEnable,
  input logic                autoExpEnable
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  logic [ADDR_W-1:0] ofs;     // Offset into the bank, wraps below it
  logic [2:0]        kind;    // Register within a group
  logic              inBank;  // Populated bank slot
  logic              wrCtl;   // Committed write touching lane 0
  logic              rdAck;   // Read answered this cycle
  assign ofs    = adr_i - BANK_BASE[ADDR_W-1:0];
  assign kind   = ofs[4:2];
  assign inBank = (ofs < ADDR_W'(BANK_SPAN)) && (kind <= KIND_AUTOEXP);
  assign wrCtl  = ack_o && cyc_i && stb_i && we_i && sel_i[0];
  assign rdAck  = ack_o && cyc_i && stb_i && !we_i;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Bus timing and read contents
  // ----------------------------------------
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
  AST_PTR_READ: assert property (rdAck && adr_i[ADDR_W-1:2] == OFS_BASE_POINTER[ADDR_W-1:2]
    |-> dat_o == BANK_BASE) else $error("pointer read wrong");
  AST_RD_FIELDS: assert property (rdAck && inBank
    |-> dat_o[0] == PRESENT && dat_o[5:1] == 5'h00 && dat_o[19:8] == 12'h000) else $error("fixed bits wrong");
  AST_RD_GAIN_EN: assert property (rdAck && inBank && kind == KIND_GAIN
    |-> dat_o[6] == gainEnable) else $error("gain enable readback wrong");
  // ----------------------------------------
  // Cross-coupled enables, one edge after the write
  // ----------------------------------------
  AST_GAIN_WR: assert property (wrCtl && inBank && kind == KIND_GAIN |=>
    gainEnable == $past(dat_i[6]) && autoExpEnable != $past(dat_i[6])) else $error("gain enable write");
  AST_SHUT_WR: assert property (wrCtl && inBank && kind == KIND_SHUTTER |=>
    shutterEnable == $past(dat_i[6]) && autoExpEnable != $past(dat_i[6])) else $error("shutter enable write");
  AST_AE_WR: assert property (wrCtl && inBank && kind == KIND_AUTOEXP |=> autoExpEnable == $past(dat_i[6])
    && gainEnable != $past(dat_i[6]) && shutterEnable != $past(dat_i[6])) else $error("autoexp enable write");
  AST_GLB_GAIN: assert property (wrCtl && adr_i[ADDR_W-1:2] == OFS_GLOBAL_GAIN[ADDR_W-1:2]
    |=> gainEnable != $past(dat_i[6])) else $error("global gain coupling");
  AST_GLB_SHUT: assert property (wrCtl && adr_i[ADDR_W-1:2] == OFS_GLOBAL_SHUTTER[ADDR_W-1:2]
    |=> shutterEnable != $past(dat_i[6])) else $error("global shutter coupling");
  AST_EN_HOLD: assert property (!(ack_o && we_i)
    |=> $stable({gainEnable, shutterEnable, autoExpEnable})) else $error("enables moved without write");

  // Main scenarios reached
  cover property (wrCtl && inBank && kind == KIND_AUTOEXP);
  cover property (wrCtl && adr_i[ADDR_W-1:2] == OFS_GLOBAL_GAIN[ADDR_W-1:2]);
  cover property (rdAck && inBank && dat_o[7]);
endmodule // per_sensor_exposure_regs_chk

bind per_sensor_exposure_regs per_sensor_exposure_regs_chk #(
  .ADDR_W(ADDR_W), .BANK_BASE(BANK_BASE), .PRESENT(PRESENT)) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .gainEnable(gainEnable),
  .shutterEnable(shutterEnable), .autoExpEnable(autoExpEnable));

// ==== bench/per_sensor_exposure_regs_test.sv ====
`timescale 1ns/1ps
module per_sensor_exposure_regs_test;
  import exposure_pkg::*;
  // ----------------------------------------
  // Bench signals and reference state
  // ----------------------------------------
  localparam logic [15:0] BASE = 16'h3000;  // Bank moved off its default
  logic        clk, rstN, cyc, stb, we, ack, gEnO, sEnO, aEnO;
  logic [15:0] adr;
  logic [31:0] dat, datO, rd, wd;
  logic [3:0]  sel, ws;
  int          err_total, compares, cycles, idx, k;
  bit          gEn, sEn, aEn;    // Model enables
  bit          modeM[20];        // Model mode bits
  logic [11:0] valM[20];         // Model value fields

  per_sensor_exposure_regs #(.ADDR_W(16), .BANK_BASE(32'h0000_3000), .PRESENT(1'b1)) dut (
    .sys_clk(clk), .rst_n(rstN), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat),
    .sel_i(sel), .dat_o(datO), .ack_o(ack), .gainEnable(gEnO), .shutterEnable(sEnO), .autoExpEnable(aEnO));

  always #5 clk = ~clk;

  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Reference model: 0-17 sensors, 18/19 globals, 20 pointer, rest unmapped
  // ----------------------------------------
  function automatic bit enOf(int i);
    if (i == 18) return !sEn;
    if (i == 19) return !gEn;
    return (i % 3 == 0) ? gEn : (i % 3 == 1) ? sEn : aEn;
  endfunction

  function automatic logic [15:0] addrOf(int i);
    case (i)
      18: return 16'h081C;
      19: return 16'h0820;
      20: return 16'h1E94;
      21: return BASE + 16'h000C;  // Gap inside a group
      22: return BASE + 16'h00BC;
      23: return BASE + 16'h00C0;  // Just past the bank
      default: return BASE + 16'(i / 3 * 32 + i % 3 * 4);
    endcase
  endfunction

  function automatic logic [31:0] expOf(int i);
    if (i < 20) return {valM[i], 12'h000, modeM[i], enOf(i), 5'h00, 1'b1};
    return (i == 20) ? {16'h0000, BASE} : 32'h0000_0000;
  endfunction

  // Gating uses enable and mode from before the write
  task automatic mWrite(int i, logic [31:0] d, logic [3:0] s);
    bit en, md;
    if (i >= 20) return;
    en = enOf(i);
    md = modeM[i];
    if (s[0] && en) modeM[i] = d[7];
    if (en && !md && s[2]) valM[i][3:0] = d[23:20];
    if (en && !md && s[3]) valM[i][11:4] = d[31:24];
    if (!s[0]) return;
    k = (i >= 18) ? i - 15 : i % 3;
    gEn = (k == 0) ? d[6] : (k == 2 || k == 4) ? !d[6] : gEn;
    sEn = (k == 1) ? d[6] : (k == 2 || k == 3) ? !d[6] : sEn;
    aEn = (k == 2) ? d[6] : (k < 2) ? !d[6] : aEn;
  endtask

  // ----------------------------------------
  // Compare, bus and reset tasks
  // ----------------------------------------
  task automatic chkWord(logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chkFlags(logic [2:0] e, logic [2:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask

  // Classic cycle; ack and read data taken at the same rising edge, released right after it
  task automatic wb(bit w, logic [15:0] a, logic [31:0] d, logic [3:0] s, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    r = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic doReset();
    rstN <= 1'b0;
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    {gEn, sEn, aEn} = 3'h1;
    foreach (modeM[i]) modeM[i] = 1'b0;
    foreach (valM[i]) valM[i] = 12'h000;
  endtask

  // Every slot read back, then the enable pins
  task automatic sweep();
    for (int i = 0; i < 24; i++) begin
      wb(1'b0, addrOf(i), 32'h0000_0000, 4'hF, rd);
      chkWord(expOf(i), rd);
    end
    chkFlags({gEn, sEn, aEn}, {gEnO, sEnO, aEnO});
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence: random writes anywhere, full readback each time
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rstN = 1'b0;
    {cyc, stb, we, adr, dat, sel} = '0;
    err_total = 0;
    compares = 0;
    cycles = 0;
    void'($urandom(32'hcf4b));
    doReset();
    sweep();
    for (int n = 0; n < 150; n++) begin
      idx = $urandom % 24;
      wd = $urandom;
      ws = 4'($urandom);
      if (n == 75) doReset();  // Second reset in mid-run
      wb(1'b1, addrOf(idx), wd, ws, rd);
      mWrite(idx, wd, ws);
      sweep();
    end
    finish_test();
  end
endmodule // per_sensor_exposure_regs_test
